// *** src/scr_top.sv ***
`timescale 1ns/1ps
module scr_top #(
	parameter int LINE_DEPTH = scr_pkg::LINE_DEPTH,
	parameter int BIT_CYC = scr_pkg::BIT_CYC
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// serial link
	input wire logic RXD,
	output logic TXD,
	// controller state
	input wire logic [7:0] POWER_BCD,
	output logic LASER_ON
);
	localparam int AW = $clog2(LINE_DEPTH) + 1;
	localparam int CW = $clog2(BIT_CYC);
	localparam logic [CW-1:0] BIT_RL = CW'(BIT_CYC - 1);
	localparam logic [CW-1:0] HALF_RL = CW'(BIT_CYC / 2 - 1);
	localparam logic [AW-1:0] LINE_MAX = AW'(LINE_DEPTH);

	typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} scr_rx_t;
	typedef enum {TX_IDLE, TX_RUN} scr_tx_t;
	typedef enum {S_LINE, S_HEAD, S_TAIL, S_PARSE, S_EMIT} scr_st_t;

	// receiver, 8N1 with no handshake lines
	logic rx_s1, rx_s2;
	scr_rx_t rx_st, next_rx_st;
	logic [CW-1:0] rx_cnt, next_rx_cnt;
	logic [3:0] rx_bit, next_rx_bit;
	logic [7:0] rx_sh, next_rx_sh;
	logic rx_vld, next_rx_vld;

	always_ff @(posedge CLK) begin
		rx_s1 <= RESET ? 1'b1 : RXD;
		rx_s2 <= RESET ? 1'b1 : rx_s1;
	end

	always_comb begin
		next_rx_st = rx_st;
		next_rx_cnt = rx_cnt == '0 ? rx_cnt : rx_cnt - CW'(1);
		next_rx_bit = rx_bit;
		next_rx_sh = rx_sh;
		next_rx_vld = 1'b0;
		unique case (rx_st)
			RX_IDLE: if (!rx_s2) begin
				next_rx_st = RX_START;
				next_rx_cnt = HALF_RL;
			end
			RX_START: if (rx_cnt == '0) begin
				next_rx_st = rx_s2 ? RX_IDLE : RX_DATA;
				next_rx_cnt = BIT_RL;
				next_rx_bit = 4'h0;
			end
			RX_DATA: if (rx_cnt == '0) begin
				next_rx_sh = {rx_s2, rx_sh[7:1]};
				next_rx_bit = rx_bit + 4'h1;
				next_rx_cnt = BIT_RL;
				if (rx_bit == 4'(scr_pkg::DATA_BITS - 1))
					next_rx_st = RX_STOP;
			end
			RX_STOP: if (rx_cnt == '0) begin
				next_rx_vld = rx_s2;
				next_rx_st = RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			rx_st <= RX_IDLE;
			rx_cnt <= '0;
			rx_bit <= 4'h0;
			rx_sh <= 8'h00;
			rx_vld <= 1'b0;
		end else begin
			rx_st <= next_rx_st;
			rx_cnt <= next_rx_cnt;
			rx_bit <= next_rx_bit;
			rx_sh <= next_rx_sh;
			rx_vld <= next_rx_vld;
		end
	end

	// line store, trim, parse and reply generation
	logic [7:0] line [LINE_DEPTH];
	logic [7:0] next_line [LINE_DEPTH];
	scr_st_t st, next_st;
	logic [AW-1:0] len, next_len, head, next_head, tail, next_tail;
	scr_pkg::scr_reply_t kind, next_kind;
	logic [AW:0] idx, next_idx, rlen;
	logic laser, next_laser;
	logic in_valid, in_ready;
	scr_pkg::scr_char_t ch;
	logic [7:0] c0, c1;

	function automatic logic is_ws(input logic [7:0] c);
		return c == scr_pkg::CH_SP || c == scr_pkg::CH_TAB;
	endfunction

	assign c0 = line[head[AW-2:0]];
	assign c1 = line[AW'(head + AW'(1)) % LINE_DEPTH];
	assign in_valid = st == S_EMIT;

	always_comb begin
		unique case (kind)
			scr_pkg::RP_OK: rlen = (AW+1)'(2);
			scr_pkg::RP_STATE: rlen = (AW+1)'(1);
			scr_pkg::RP_POWER: rlen = (AW+1)'(3);
			scr_pkg::RP_ERROR: rlen = (AW+1)'(scr_pkg::ERR_LEN) + (AW+1)'(len);
		endcase
		ch.last = idx == rlen;
		ch.data = scr_pkg::CH_CR;
		if (!ch.last) begin
			unique case (kind)
				scr_pkg::RP_OK: ch.data = idx == '0 ? scr_pkg::CH_O : scr_pkg::CH_K;
				scr_pkg::RP_STATE: ch.data = laser ? scr_pkg::CH_ONE : scr_pkg::CH_ZERO;
				scr_pkg::RP_POWER: begin
					if (idx == (AW+1)'(1))
						ch.data = scr_pkg::CH_DOT;
					else if (idx == '0)
						ch.data = scr_pkg::CH_ZERO | {4'h0, POWER_BCD[7:4]};
					else
						ch.data = scr_pkg::CH_ZERO | {4'h0, POWER_BCD[3:0]};
				end
				scr_pkg::RP_ERROR: begin
					if (idx < (AW+1)'(scr_pkg::ERR_LEN))
						ch.data = scr_pkg::scr_err_char(idx[3:0]);
					else
						ch.data = line[(idx - (AW+1)'(scr_pkg::ERR_LEN)) % LINE_DEPTH];
				end
			endcase
		end
	end

	always_comb begin
		next_line = line;
		next_st = st;
		next_len = len;
		next_head = head;
		next_tail = tail;
		next_kind = kind;
		next_idx = idx;
		next_laser = laser;
		unique case (st)
			S_LINE: if (rx_vld) begin
				if (rx_sh == scr_pkg::CH_CR) begin
					next_st = S_HEAD;
					next_head = '0;
					next_tail = len;
				end else if (len != LINE_MAX) begin
					next_line[len[AW-2:0]] = rx_sh;
					next_len = len + AW'(1);
				end
			end
			S_HEAD: if (head != tail && is_ws(c0))
				next_head = head + AW'(1);
			else
				next_st = S_TAIL;
			S_TAIL: if (tail != head && is_ws(line[(tail - AW'(1)) % LINE_DEPTH]))
				next_tail = tail - AW'(1);
			else
				next_st = S_PARSE;
			S_PARSE: begin
				next_st = S_EMIT;
				next_idx = '0;
				next_kind = scr_pkg::RP_ERROR;
				if (tail - head == AW'(2)) begin
					// exact byte compare, so upper case never matches
					if (c0 == scr_pkg::CH_LL && c1 == scr_pkg::CH_ONE) begin
						next_kind = scr_pkg::RP_OK;
						next_laser = 1'b1;
					end else if (c0 == scr_pkg::CH_LL && c1 == scr_pkg::CH_ZERO) begin
						next_kind = scr_pkg::RP_OK;
						next_laser = 1'b0;
					end else if (c0 == scr_pkg::CH_LL && c1 == scr_pkg::CH_QM)
						next_kind = scr_pkg::RP_STATE;
					else if (c0 == scr_pkg::CH_LP && c1 == scr_pkg::CH_QM)
						next_kind = scr_pkg::RP_POWER;
				end
			end
			S_EMIT: if (in_ready) begin
				next_idx = idx + (AW+1)'(1);
				if (ch.last) begin
					next_st = S_LINE;
					next_len = '0;
				end
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		line <= next_line;
		if (RESET) begin
			st <= S_LINE;
			len <= '0;
			head <= '0;
			tail <= '0;
			kind <= scr_pkg::RP_OK;
			idx <= '0;
			laser <= scr_pkg::LASER_RESET;
		end else begin
			st <= next_st;
			len <= next_len;
			head <= next_head;
			tail <= next_tail;
			kind <= next_kind;
			idx <= next_idx;
			laser <= next_laser;
		end
	end

	assign LASER_ON = laser;

	// transmitter fed from the two-entry buffer
	logic out_valid;
	scr_pkg::scr_char_t out_ch;
	scr_tx_t tx_st, next_tx_st;
	logic [CW-1:0] tx_cnt, next_tx_cnt;
	logic [3:0] tx_bit, next_tx_bit;
	logic [8:0] tx_sh, next_tx_sh;
	logic next_txd;

	scr_buf #(.W($bits(scr_pkg::scr_char_t))) u_buf (
		.clk(CLK),
		.reset(RESET),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data(ch),
		.out_valid(out_valid),
		.out_ready(tx_st == TX_IDLE),
		.out_data(out_ch)
	);

	always_comb begin
		next_tx_st = tx_st;
		next_tx_cnt = tx_cnt == '0 ? tx_cnt : tx_cnt - CW'(1);
		next_tx_bit = tx_bit;
		next_tx_sh = tx_sh;
		next_txd = TXD;
		unique case (tx_st)
			TX_IDLE: if (out_valid) begin
				next_tx_st = TX_RUN;
				next_tx_sh = {1'b1, out_ch.data};
				next_txd = 1'b0;
				next_tx_cnt = BIT_RL;
				next_tx_bit = 4'h0;
			end
			TX_RUN: if (tx_cnt == '0) begin
				if (tx_bit == 4'(scr_pkg::FRAME_BITS)) begin
					next_tx_st = TX_IDLE;
				end else begin
					next_txd = tx_sh[0];
					next_tx_sh = {1'b1, tx_sh[8:1]};
					next_tx_bit = tx_bit + 4'h1;
					next_tx_cnt = BIT_RL;
				end
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			tx_st <= TX_IDLE;
			tx_cnt <= '0;
			tx_bit <= 4'h0;
			tx_sh <= 9'h1ff;
			TXD <= 1'b1;
		end else begin
			tx_st <= next_tx_st;
			tx_cnt <= next_tx_cnt;
			tx_bit <= next_tx_bit;
			tx_sh <= next_tx_sh;
			TXD <= next_txd;
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	property p_no_unprompted;
		$rose(in_valid) |-> $past(st) == S_PARSE;
	endproperty
	a_no_unprompted: assert property (p_no_unprompted) else $error("reply without message");
	property p_cr_reply;
		st == S_LINE && rx_vld && rx_sh == scr_pkg::CH_CR |=> ##[1:80] st == S_EMIT;
	endproperty
	a_cr_reply: assert property (p_cr_reply) else $error("no reply after CR");
	property p_err_head;
		st == S_EMIT && kind == scr_pkg::RP_ERROR && idx == '0 |-> ch.data == scr_pkg::CH_S;
	endproperty
	a_err_head: assert property (p_err_head) else $error("error reply bad start");
	property p_end_cr;
		in_valid && in_ready && ch.last |-> ch.data == scr_pkg::CH_CR ##1 st == S_LINE;
	endproperty
	a_end_cr: assert property (p_end_cr) else $error("reply not ended by CR");
	property p_dot;
		in_valid && kind == scr_pkg::RP_POWER && idx == (AW+1)'(1) |-> ch.data == scr_pkg::CH_DOT;
	endproperty
	a_dot: assert property (p_dot) else $error("separator not a period");
	property p_baud;
		tx_st == TX_RUN && $changed(TXD) |-> $past(tx_cnt) == '0;
	endproperty
	a_baud: assert property (p_baud) else $error("tx bit edge off grid");
	property p_frame;
		tx_st == TX_IDLE && out_valid |=> !TXD && tx_bit == 4'h0;
	endproperty
	a_frame: assert property (p_frame) else $error("start bit missing");
	property p_stop;
		tx_st == TX_RUN && tx_bit == 4'(scr_pkg::FRAME_BITS) |-> TXD;
	endproperty
	a_stop: assert property (p_stop) else $error("stop bit low");
	property p_trim;
		st == S_PARSE && tail != head |-> !is_ws(c0) && !is_ws(line[(tail - AW'(1)) % LINE_DEPTH]);
	endproperty
	a_trim: assert property (p_trim) else $error("whitespace not trimmed");
	property p_case;
		st == S_PARSE ##1 kind != scr_pkg::RP_ERROR |-> $past(c0) inside {scr_pkg::CH_LL, scr_pkg::CH_LP};
	endproperty
	a_case: assert property (p_case) else $error("keyword case mismatch");
	property p_after_cr;
		$rose(st == S_HEAD) |-> $past(rx_vld) && $past(rx_sh) == scr_pkg::CH_CR;
	endproperty
	a_after_cr: assert property (p_after_cr) else $error("parse before CR");

	c_ok: cover property (st == S_PARSE ##1 kind == scr_pkg::RP_OK);
	c_err: cover property (st == S_PARSE ##1 kind == scr_pkg::RP_ERROR);
	c_pwr: cover property (st == S_PARSE ##1 kind == scr_pkg::RP_POWER);
	c_full: cover property (in_valid && !in_ready);
endmodule

// *** include/scr_pkg.sv ***
// Operation
// - never transmit except as a reply
// - exactly one reply per received message; a CR received before the previous reply is fully queued gets none
// - bad command echoes Syntax error plus command
// - every reply ends with carriage return
// - fractional values use a period separator
// - link runs fixed at 115200 baud
// - eight data bits, one stop, no parity
// - no hardware flow control lines
// - command keywords compared case sensitively
// - leading and trailing whitespace is discarded; the error reply still echoes the untrimmed line, whitespace included
package scr_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int BAUD = 115200;
	localparam int BIT_CYC = CLK_HZ / BAUD;
	localparam int HALF_CYC = BIT_CYC / 2;
	localparam int DATA_BITS = 8;
	localparam int FRAME_BITS = DATA_BITS + 1;
	localparam int LINE_DEPTH = 32;
	localparam int ERR_LEN = 13;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_TAB = 8'h09;
	localparam logic [7:0] CH_DOT = 8'h2e;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_ONE = 8'h31;
	localparam logic [7:0] CH_QM = 8'h3f;
	localparam logic [7:0] CH_O = 8'h4f;
	localparam logic [7:0] CH_K = 8'h4b;
	localparam logic [7:0] CH_LL = 8'h6c;
	localparam logic [7:0] CH_LP = 8'h70;
	localparam logic [7:0] CH_S = 8'h53;
	localparam logic LASER_RESET = 1'b0;

	typedef enum logic [1:0] {RP_OK, RP_STATE, RP_POWER, RP_ERROR} scr_reply_t;

	// one reply character on its way to the transmitter
	typedef struct packed {
		logic last;
		logic [7:0] data;
	} scr_char_t;

	function automatic logic [7:0] scr_err_char(input logic [3:0] i);
		case (i)
			4'h0: return CH_S;
			4'h1: return 8'h79;
			4'h2: return 8'h6e;
			4'h3: return 8'h74;
			4'h4: return 8'h61;
			4'h5: return 8'h78;
			4'h6: return CH_SP;
			4'h7: return 8'h65;
			4'h8: return 8'h72;
			4'h9: return 8'h72;
			4'ha: return 8'h6f;
			4'hb: return 8'h72;
			default: return 8'h3a;
		endcase
	endfunction
endpackage

// *** src/scr_buf.sv ***
`timescale 1ns/1ps
module scr_buf #(
	parameter int W = 9
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] mem [2];
	logic [W-1:0] next_mem [2];
	logic wp, rp, next_wp, next_rp;
	logic [1:0] cnt, next_cnt;
	logic push, pop;

	assign in_ready = cnt != 2'h2;
	assign out_valid = cnt != 2'h0;
	assign out_data = mem[rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		next_mem = mem;
		next_wp = wp;
		next_rp = rp;
		next_cnt = cnt;
		if (push) begin
			next_mem[wp] = in_data;
			next_wp = ~wp;
		end
		if (pop)
			next_rp = ~rp;
		if (push && !pop)
			next_cnt = cnt + 2'h1;
		else if (pop && !push)
			next_cnt = cnt - 2'h1;
	end

	always_ff @(posedge clk) begin
		mem <= next_mem;
		if (reset) begin
			wp <= 1'b0;
			rp <= 1'b0;
			cnt <= 2'h0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
			cnt <= next_cnt;
		end
	end
endmodule

// *** sim/scr_host.sv ***
`timescale 1ns/1ps
module scr_host #(
	parameter int BIT = scr_pkg::BIT_CYC
) (
	// clock
	input wire logic clk,
	// serial lines seen from the host
	output logic line_out,
	input wire logic line_in
);
	initial line_out = 1'b1;

	// start, 8 data lsb first, one stop, no parity; no handshake lines
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			line_out <= frame[i];
			repeat (BIT - 1) @(posedge clk);
		end
	endtask

	// the string is sent byte for byte as given, whitespace included; the caller adds the CR
	task automatic send_text(input string s);
		for (int i = 0; i < s.len(); i++) begin
			send_byte(s[i]);
		end
	endtask

	// samples each bit at its middle; good only if the stop bit reads high
	task automatic recv_byte(input int limit, output logic [7:0] b, output logic good);
		int n;
		b = 8'h00;
		good = 1'b0;
		n = 0;
		while (line_in !== 1'b0 && n < limit) begin
			@(posedge clk);
			n++;
		end
		if (line_in !== 1'b0) begin
			return;
		end
		repeat (BIT / 2) @(posedge clk);
		if (line_in !== 1'b0) begin
			return;
		end
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk);
			b[i] = line_in;
		end
		repeat (BIT) @(posedge clk);
		good = (line_in === 1'b1);
	endtask

	// collects characters up to and including the CR
	task automatic recv_line(output string s, output logic good);
		logic [7:0] b;
		int limit;
		s = "";
		good = 1'b1;
		b = 8'h00;
		// one frame for the CR, then trim and parse time of a full line
		limit = 12 * BIT + 100;
		while (good === 1'b1 && b !== scr_pkg::CH_CR && s.len() < 48) begin
			recv_byte(limit, b, good);
			if (good === 1'b1) begin
				s = $sformatf("%s%c", s, b);
			end
			limit = 2 * BIT;
		end
	endtask
endmodule

// *** sim/scr_top_tb.sv ***
`timescale 1ns/1ps
module scr_top_tb;
	// short bit time keeps the run brief; the divider logic is the same at any ratio
	localparam int BIT = 20;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic rxd;
	logic txd;
	logic [7:0] power_bcd = 8'h00;
	logic laser_on;
	logic quiet = 1'b0;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;

	always #5 clk = ~clk;

	scr_top #(.BIT_CYC(BIT)) dut_u (
		.CLK(clk),
		.RESET(reset),
		.RXD(rxd),
		.TXD(txd),
		.POWER_BCD(power_bcd),
		.LASER_ON(laser_on)
	);

	scr_host #(.BIT(BIT)) host_u (
		.clk(clk),
		.line_out(rxd),
		.line_in(txd)
	);

	task automatic bad_one(input string msg);
		err_count++;
		$display("Error at %0t: %s", $time, msg);
	endtask

	task automatic finish_test();
		$display("Checks: %0d, errors: %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// the line must stay idle whenever no reply is owed
	always @(posedge clk) begin
		cycles++;
		if (quiet && txd !== 1'b1) begin
			bad_one("transmitter active without a finished command");
			quiet = 1'b0;
		end
		if (cycles == 40000) begin
			bad_one("run did not finish in time");
			finish_test();
		end
	end

	// sends a line, takes the reply, then demands silence for two bit times' worth
	task automatic exchange(input string cmd, input string exp, input string what);
		string got;
		logic good;
		quiet = 1'b1;
		host_u.send_text(cmd);
		quiet = 1'b0;
		fork
			host_u.send_byte(scr_pkg::CH_CR);
			host_u.recv_line(got, good);
		join
		samples_checked++;
		if (good !== 1'b1 || got != exp) begin
			bad_one($sformatf("%s reply wrong: %s", what, got));
		end
		quiet = 1'b1;
		repeat (2 * BIT) @(posedge clk);
	endtask

	task automatic t_laser_on();
		exchange(" l1\t", "OK\015", "laser on");
		samples_checked++;
		if (laser_on !== 1'b1) begin
			bad_one("laser enable not set");
		end
	endtask

	task automatic t_query();
		exchange("l?", "1\015", "state query on");
	endtask

	task automatic t_laser_off();
		exchange("l0 ", "OK\015", "laser off");
		samples_checked++;
		if (laser_on !== 1'b0) begin
			bad_one("laser enable not cleared");
		end
		exchange("l?", "0\015", "state query off");
	endtask

	task automatic t_blank();
		exchange("  ", "Syntax error:  \015", "blank line");
	endtask

	task automatic t_power();
		@(posedge clk);
		power_bcd <= 8'h47;
		@(posedge clk);
		exchange("p?", "4.7\015", "power");
	endtask

	task automatic t_bad_case();
		exchange("L0", "Syntax error:L0\015", "case");
		samples_checked++;
		if (laser_on !== 1'b1) begin
			bad_one("uninterpretable command changed the laser");
		end
	endtask

	initial begin
		repeat (2) @(posedge clk);
		quiet = 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		samples_checked++;
		if (laser_on !== 1'b0) begin
			bad_one("laser enable not clear after reset");
		end
		t_laser_on();
		t_power();
		t_bad_case();
		t_query();
		t_laser_off();
		t_blank();
		finish_test();
	end
endmodule
